// [hw/lnmc_params.svh]
/*
 Constants for the LIN node mode and control block: register offsets, bit positions,
 reset values and payload size codes.
 Assumes it is included by bare name from design files.
*/
`ifndef LNMC_PARAMS_SVH
`define LNMC_PARAMS_SVH

// ---------------------------------------------
// Register locations
// ---------------------------------------------
`define LNMC_MODE_ADDR 8'hC9
`define LNMC_IDX_ADDR 8'hD1
`define LNMC_DATA_ADDR 8'hD2
`define LNMC_CTRL_IDX 8'h08
`define LNMC_ID_IDX 8'h0E

// ---------------------------------------------
// Mode register fields and reset
// ---------------------------------------------
`define LNMC_MODE_EN 7
`define LNMC_MODE_ROLE 6
`define LNMC_MODE_AUTO_RATE_SELECT 5
`define LNMC_MODE_RESET 8'h60

// ---------------------------------------------
// Control register fields and reset
// ---------------------------------------------
`define LNMC_CTL_HALT 7
`define LNMC_CTL_SLEEP 6
`define LNMC_CTL_DIR 5
`define LNMC_CTL_DACK 4
`define LNMC_CTL_ICLR 3
`define LNMC_CTL_ECLR 2
`define LNMC_CTL_WAKE 1
`define LNMC_CTL_START 0
`define LNMC_CTL_RESET 8'h00

// ---------------------------------------------
// Payload size
// ---------------------------------------------
`define LNMC_SIZE_FROM_ID 4'hF

`endif

// [hw/lnmc_pkg.sv]
/*
 Types for the LIN node mode and control block.
 Assumes the params header is compiled alongside.
*/
package lnmc_pkg;
   // Node activity state, one-hot
   typedef enum logic [3:0]
   {
      LNMC_OFF = 4'h1,
      LNMC_RUN = 4'h2,
      LNMC_HALT = 4'h4,
      LNMC_SLEEP = 4'h8
   } lnmc_state_e;
endpackage

// [hw/lnmc_cmd_if.sv]
/*
 Interface carrying decoded command strobes from the register file to the node sequencer.
 Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface lnmc_cmd_if;
   logic halt;
   logic sleepEn;
   logic wake;
   logic slaveRole;
   logic enable;
   logic syncBreak;
   logic sleepFrame;
   logic idleTimeout;
   logic wakeIrq;
   lnmc_pkg::lnmc_state_e state;
   modport regs (output halt, output sleepEn, output wake, output slaveRole, output enable,
      output syncBreak, output sleepFrame, output idleTimeout, output wakeIrq,
      input state);
   modport seq (input halt, input sleepEn, input wake, input slaveRole, input enable,
      input syncBreak, input sleepFrame, input idleTimeout, input wakeIrq,
      output state);
endinterface

// [hw/lnmc_node_seq.sv]
/*
 Node activity sequencer: off, running, halted until sync break, asleep.
 Assumes command strobes are one-cycle pulses from the register file.
*/
`timescale 1ns/1ps
module lnmc_node_seq
(
   input wire logic sys_clk, // System clock
   input wire logic reset, // Async reset, active high
   lnmc_cmd_if.seq cmd // Commands and state
);
   lnmc_pkg::lnmc_state_e st;
   lnmc_pkg::lnmc_state_e next_st;

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb
   begin
      next_st = st;
      case (st)
         lnmc_pkg::LNMC_OFF:
            if (cmd.enable)
               next_st = lnmc_pkg::LNMC_RUN;
         lnmc_pkg::LNMC_RUN:
            if (cmd.slaveRole && cmd.halt)
               next_st = lnmc_pkg::LNMC_HALT;
            else if (cmd.slaveRole && cmd.sleepEn && (cmd.sleepFrame || cmd.idleTimeout))
               next_st = lnmc_pkg::LNMC_SLEEP;
         lnmc_pkg::LNMC_HALT:
            if (cmd.syncBreak)
               next_st = lnmc_pkg::LNMC_RUN;
         lnmc_pkg::LNMC_SLEEP:
            if (cmd.wake || (!cmd.sleepEn && cmd.wakeIrq))
               next_st = lnmc_pkg::LNMC_RUN;
         default:
            next_st = lnmc_pkg::LNMC_OFF;
      endcase
      if (!cmd.enable)
         next_st = lnmc_pkg::LNMC_OFF;
   end

   // State register
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         st <= lnmc_pkg::LNMC_OFF;
      else
         st <= next_st;
   end

   assign cmd.state = st;

   // While enabled, a halted node leaves only on a sync break
   property p_halt_hold;
      @(posedge sys_clk) disable iff (reset)
      (st == lnmc_pkg::LNMC_HALT) && cmd.enable && !cmd.syncBreak
         |=> (st == lnmc_pkg::LNMC_HALT);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt left early");
endmodule

// [hw/lnmc_top.sv]
/*
 LIN node mode and control registers: mode register on the direct register port,
 control and identifier registers reached through an index and data pair.
 Assumes a byte-wide register port synchronous to sys_clk, and a frame engine outside
 that reports completion, errors, sync breaks, sleep frames, timeouts and wake events.
*/
`timescale 1ns/1ps
`include "lnmc_params.svh"
module lnmc_top
(
   input wire logic sys_clk, // System clock, 10 MHz
   input wire logic reset, // Async reset, active high
   input wire logic [7:0] regAddr, // Register address
   input wire logic regWrite, // Write strobe
   input wire logic regRead, // Read strobe
   input wire logic [7:0] regWdata, // Write data
   output logic [7:0] regRdata, // Read data, registered
   input wire logic [3:0] payloadSize, // Size field from frame engine
   input wire logic frameDone, // Frame completed pulse
   input wire logic frameError, // Frame error pulse
   input wire logic dataAckTaken, // Engine consumed data ack pulse
   input wire logic wakeSent, // Wakeup signal sent pulse
   input wire logic syncBreak, // Sync break detected pulse
   input wire logic sleepFrame, // Sleep frame received pulse
   input wire logic idleTimeout, // Bus idle timeout pulse
   input wire logic wakeIrq, // Wakeup interrupt pulse
   output logic ifaceActive, // Controller not off: running, halted or asleep
   output logic masterRole, // Master role active
   output logic autoRate, // Automatic rate in effect
   output logic frameTransmit, // Frame is transmit
   output logic dataAck, // Data ack pending
   output logic startFrame, // Start request pending
   output logic wakeSend, // Send wakeup signal
   output logic irqFlagClear, // Clear frame interrupt flag pulse
   output logic errorFlagsClear, // Clear error bits pulse
   output logic trafficIgnored, // Ignoring bus traffic
   output logic asleep, // Node in sleep
   output logic [5:0] frameId, // Identifier
   output logic [3:0] payloadBytes // Data length in bytes
);
   logic [7:0] mode;
   logic [7:0] ctrl;
   logic [7:0] idx;
   logic [5:0] ident;
   lnmc_cmd_if cmd ();

   // ---------------------------------------------
   // Address decode
   // ---------------------------------------------
   wire selMode = regAddr == `LNMC_MODE_ADDR;
   wire selIdx = regAddr == `LNMC_IDX_ADDR;
   wire selData = regAddr == `LNMC_DATA_ADDR;
   wire ctrlWr = regWrite && selData && (idx == `LNMC_CTRL_IDX);
   wire idWr = regWrite && selData && (idx == `LNMC_ID_IDX);
   wire isSlave = !mode[`LNMC_MODE_ROLE];
   wire wrHalt = ctrlWr && regWdata[`LNMC_CTL_HALT];

   // Payload length from size field or identifier
   function automatic logic [3:0] lnmc_len(input logic [3:0] sz, input logic [1:0] idHi);
      if (sz != `LNMC_SIZE_FROM_ID)
         lnmc_len = sz;
      else
         case (idHi)
            2'h2: lnmc_len = 4'h4;
            2'h3: lnmc_len = 4'h8;
            default: lnmc_len = 4'h2;
         endcase
   endfunction

   // ---------------------------------------------
   // Mode, index and identifier registers
   // ---------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         mode <= `LNMC_MODE_RESET;
         idx <= 8'h00;
         ident <= 6'h00;
      end
      else
      begin
         if (regWrite && selMode)
            mode <= {regWdata[7:5], 5'h00};
         if (regWrite && selIdx)
            idx <= regWdata;
         if (idWr)
            ident <= regWdata[5:0];
      end
   end

   // Control register; a write setting a bit wins over the hardware clear that finishes its action
   // Command bits 7, 3, 2 are never stored so they read zero
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         ctrl <= `LNMC_CTL_RESET;
      else
      begin
         if (ctrlWr)
            ctrl <= {1'b0, regWdata[6:4], 2'h0, regWdata[1:0]};
         if (dataAckTaken && !(ctrlWr && regWdata[`LNMC_CTL_DACK]))
            ctrl[`LNMC_CTL_DACK] <= 1'b0;
         if (wakeSent && !(ctrlWr && regWdata[`LNMC_CTL_WAKE]))
            ctrl[`LNMC_CTL_WAKE] <= 1'b0;
         if ((frameDone || frameError) && !(ctrlWr && regWdata[`LNMC_CTL_START]))
            ctrl[`LNMC_CTL_START] <= 1'b0;
      end
   end

   // Read data path, unmapped reads give zero
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         regRdata <= 8'h00;
      else if (regRead)
         regRdata <= selMode ? mode : selIdx ? idx :
            (selData && idx == `LNMC_CTRL_IDX) ? ctrl :
            (selData && idx == `LNMC_ID_IDX) ? {2'h0, ident} : 8'h00;
   end

   // Command pulses for the frame engine
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         irqFlagClear <= 1'b0;
         errorFlagsClear <= 1'b0;
      end
      else
      begin
         irqFlagClear <= ctrlWr && regWdata[`LNMC_CTL_ICLR];
         errorFlagsClear <= ctrlWr && regWdata[`LNMC_CTL_ECLR];
      end
   end

   // ---------------------------------------------
   // Sequencer hookup
   // ---------------------------------------------
   assign cmd.halt = wrHalt;
   assign cmd.sleepEn = ctrl[`LNMC_CTL_SLEEP];
   // A wake request ends sleep only once the wakeup has gone out, so the request bit clears with it
   assign cmd.wake = ctrl[`LNMC_CTL_WAKE] && wakeSent;
   assign cmd.slaveRole = isSlave;
   assign cmd.enable = mode[`LNMC_MODE_EN];
   assign cmd.syncBreak = syncBreak;
   assign cmd.sleepFrame = sleepFrame;
   assign cmd.idleTimeout = idleTimeout;
   assign cmd.wakeIrq = wakeIrq;

   lnmc_node_seq lnmc_node_seq_inst
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .cmd(cmd)
   );

   // Outputs; role bits act whether or not the node is enabled
   assign ifaceActive = cmd.state != lnmc_pkg::LNMC_OFF;
   assign masterRole = mode[`LNMC_MODE_ROLE];
   assign autoRate = isSlave && mode[`LNMC_MODE_AUTO_RATE_SELECT];
   assign frameTransmit = ctrl[`LNMC_CTL_DIR];
   assign dataAck = isSlave && ctrl[`LNMC_CTL_DACK];
   assign startFrame = !isSlave && ctrl[`LNMC_CTL_START];
   assign wakeSend = ctrl[`LNMC_CTL_WAKE] && (cmd.state == lnmc_pkg::LNMC_SLEEP);
   assign trafficIgnored = cmd.state == lnmc_pkg::LNMC_HALT;
   assign asleep = cmd.state == lnmc_pkg::LNMC_SLEEP;
   assign frameId = ident;
   assign payloadBytes = lnmc_len(payloadSize, ident[5:4]);

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   property p_off;
      @(posedge sys_clk) disable iff (reset) !mode[`LNMC_MODE_EN] |=> !ifaceActive;
   endproperty
   a_off: assert property (p_off) else $error("active while disabled");
   property p_auto;
      @(posedge sys_clk) disable iff (reset) masterRole |-> !autoRate;
   endproperty
   a_auto: assert property (p_auto) else $error("auto rate in master");
   property p_low;
      @(posedge sys_clk) disable iff (reset) regWrite && selMode |=> mode[4:0] == 5'h00;
   endproperty
   a_low: assert property (p_low) else $error("mode low bits set");
   property p_cmdzero;
      @(posedge sys_clk) disable iff (reset) ctrlWr |=> ctrl[7] == 1'b0 && ctrl[3:2] == 2'h0;
   endproperty
   a_cmdzero: assert property (p_cmdzero) else $error("command bit stored");
   property p_iclr;
      @(posedge sys_clk) disable iff (reset)
      ctrlWr && regWdata[`LNMC_CTL_ICLR] |=> irqFlagClear ##1 (!irqFlagClear || ctrlWr);
   endproperty
   a_iclr: assert property (p_iclr) else $error("irq clear pulse wrong");
   property p_eclr;
      @(posedge sys_clk) disable iff (reset)
      ctrlWr && regWdata[`LNMC_CTL_ECLR] |=> errorFlagsClear;
   endproperty
   a_eclr: assert property (p_eclr) else $error("error clear missing");
   property p_start;
      @(posedge sys_clk) disable iff (reset)
      (frameDone || frameError) && !ctrlWr |=> !ctrl[`LNMC_CTL_START];
   endproperty
   a_start: assert property (p_start) else $error("start not cleared");
   property p_dack;
      @(posedge sys_clk) disable iff (reset) dataAckTaken && !ctrlWr |=> !ctrl[`LNMC_CTL_DACK];
   endproperty
   a_dack: assert property (p_dack) else $error("ack not cleared");
   property p_len;
      @(posedge sys_clk) disable iff (reset)
      payloadSize == `LNMC_SIZE_FROM_ID && ident[5:4] == 2'h3 |-> payloadBytes == 4'h8;
   endproperty
   a_len: assert property (p_len) else $error("length wrong");
   property p_wake;
      @(posedge sys_clk) disable iff (reset)
      wakeSend && wakeSent && !ctrlWr |=> !asleep && !ctrl[`LNMC_CTL_WAKE];
   endproperty
   a_wake: assert property (p_wake) else $error("wake request not finished");
   c_halt: cover property (@(posedge sys_clk) disable iff (reset)
      trafficIgnored ##1 !trafficIgnored);
   c_sleep: cover property (@(posedge sys_clk) disable iff (reset) asleep ##[1:20] !asleep);
   c_frame: cover property (@(posedge sys_clk) disable iff (reset) startFrame ##[1:50] frameDone);
endmodule

// [dv/lnmc_engine_model.sv]
/*
 Frame engine stand-in: answers start, data-ack and wake requests with done pulses.
 Assumes each request is a level that drops the cycle after its answer.
*/
`timescale 1ns/1ps
module lnmc_engine_model
(
   input wire logic sys_clk, // System clock
   input wire logic reset, // Async reset
   input wire logic slow, // Long answer delay
   input wire logic startFrame, // Frame start request
   input wire logic dataAck, // Data ack pending
   input wire logic wakeSend, // Wakeup to send
   output logic frameDone, // Frame finished pulse
   output logic dataAckTaken, // Ack consumed pulse
   output logic wakeSent // Wakeup sent pulse
);
   logic [3:0] waitCnt;
   wire logic busy = startFrame | dataAck | wakeSend;
   wire logic [3:0] delay = slow ? 4'h6 : 4'h2;

   // One answer per request; counter parks past delay to avoid a second pulse
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         waitCnt <= 4'h0;
         frameDone <= 1'h0;
         dataAckTaken <= 1'h0;
         wakeSent <= 1'h0;
      end
      else
      begin
         frameDone <= busy && waitCnt == delay && startFrame;
         dataAckTaken <= busy && waitCnt == delay && dataAck;
         wakeSent <= busy && waitCnt == delay && wakeSend;
         if (!busy)
            waitCnt <= 4'h0;
         else if (waitCnt <= delay)
            waitCnt <= waitCnt + 4'h1;
      end
   end
endmodule

// [dv/lnmc_top_tb_top.sv]
/*
 Self-checking bench for the LIN node mode and control block.
 Assumes the params header is on the include path and the engine model is compiled first.
*/
`timescale 1ns/1ps
`include "lnmc_params.svh"
module lnmc_top_tb_top;
   logic sys_clk = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, slow = 1'h0;
   logic rdSeen = 1'h0, frameDone, dataAckTaken, wakeSent, ifaceActive, masterRole;
   logic autoRate, frameTransmit, dataAck, startFrame, wakeSend, irqFlagClear;
   logic errorFlagsClear, trafficIgnored, asleep;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, d;
   logic [3:0] payloadSize = 4'hF, payloadBytes;
   logic [4:0] ev = 5'h00; // frameError, syncBreak, sleepFrame, idleTimeout, wakeIrq
   logic [5:0] frameId;
   logic [7:0] expQ[$];
   logic [31:0] seed = 32'h4D00;
   int badCount = 0, testsRun = 0;
   wire logic [3:0] watch = {wakeSend, asleep, dataAck, startFrame};

   lnmc_top lnmc_top_inst (.sys_clk, .reset, .regAddr, .regWrite, .regRead, .regWdata,
      .regRdata, .payloadSize, .frameDone, .frameError(ev[4]), .dataAckTaken, .wakeSent,
      .syncBreak(ev[3]), .sleepFrame(ev[2]), .idleTimeout(ev[1]), .wakeIrq(ev[0]),
      .ifaceActive, .masterRole, .autoRate, .frameTransmit, .dataAck, .startFrame,
      .wakeSend, .irqFlagClear, .errorFlagsClear, .trafficIgnored, .asleep, .frameId,
      .payloadBytes);
   lnmc_engine_model lnmc_engine_model_inst (.sys_clk, .reset, .slow, .startFrame,
      .dataAck, .wakeSend, .frameDone, .dataAckTaken, .wakeSent);

   // ---------------------------------------------
   // Clock, compare and bus tasks
   // ---------------------------------------------
   initial forever #50 sys_clk = ~sys_clk;

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task chk8(input logic [7:0] got, exp);
      testsRun++;
      if (got !== exp)
      begin
         badCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chkBit(input logic got, exp);
      testsRun++;
      if (got !== exp)
      begin
         badCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task finishTest();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task endTest(input string name);
      $display("test %0s done, mismatches so far %0d", name, badCount);
   endtask

   // Bus cycles start one edge later so a strobe never drops and rises in one step
   task wr(input logic [7:0] a, dat);
      @(posedge sys_clk);
      #1 regAddr = a;
      regWdata = dat;
      regWrite = 1'h1;
      @(posedge sys_clk);
      #1 regWrite = 1'h0;
   endtask

   task rd(input logic [7:0] a, exp);
      @(posedge sys_clk);
      #1 regAddr = a;
      regRead = 1'h1;
      expQ.push_back(exp);
      @(posedge sys_clk);
      #1 regRead = 1'h0;
   endtask

   task ctl(input logic [7:0] dat);
      wr(`LNMC_IDX_ADDR, `LNMC_CTRL_IDX);
      wr(`LNMC_DATA_ADDR, dat);
   endtask

   task rdCtl(input logic [7:0] exp);
      wr(`LNMC_IDX_ADDR, `LNMC_CTRL_IDX);
      rd(`LNMC_DATA_ADDR, exp);
   endtask

   task pulse(input int k);
      @(posedge sys_clk);
      #1 ev[k] = 1'h1;
      @(posedge sys_clk);
      #1 ev = 5'h00;
   endtask

   task step();
      @(posedge sys_clk);
      #1;
   endtask

   // Bounded wait for a level to drop; running out ends the run
   task waitLow(input int k);
      for (int i = 0; i < 30 && watch[k] !== 1'h0; i++)
         step();
      testsRun++;
      if (watch[k] !== 1'h0)
      begin
         badCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, watch[k], 1'h0);
         finishTest();
      end
   endtask

   // Read data lands the cycle after the strobe; compare with the oldest note
   always @(posedge sys_clk)
      rdSeen <= regRead;
   always @(negedge sys_clk)
      if (rdSeen && expQ.size() > 0)
         chk8(regRdata, expQ.pop_front());

   // Hang guard
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      badCount++;
      finishTest();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      repeat (3) @(posedge sys_clk);
      #1 reset = 1'h0;
      rd(`LNMC_MODE_ADDR, `LNMC_MODE_RESET);
      rdCtl(`LNMC_CTL_RESET);
      chkBit(masterRole, 1'h1);
      chkBit(ifaceActive, 1'h0);
      rd(8'h00, 8'h00);
      endTest("reset");
      for (int i = 0; i < 6; i++)
      begin
         d = rnd();
         wr(`LNMC_MODE_ADDR, d);
         rd(`LNMC_MODE_ADDR, d & 8'hE0);
         chkBit(masterRole, d[6]);
         chkBit(autoRate, !d[6] && d[5]);
      end
      wr(`LNMC_MODE_ADDR, 8'h60);
      step();
      chkBit(ifaceActive, 1'h0);
      wr(`LNMC_MODE_ADDR, 8'hC0);
      step();
      chkBit(ifaceActive, 1'h1);
      endTest("mode");
      ctl(8'h2C);
      chkBit(irqFlagClear, 1'h1);
      chkBit(errorFlagsClear, 1'h1);
      step();
      chkBit(irqFlagClear, 1'h0);
      chkBit(errorFlagsClear, 1'h0);
      chkBit(frameTransmit, 1'h1);
      rdCtl(8'h20);
      ctl(8'h80);
      step();
      chkBit(trafficIgnored, 1'h0);
      chkBit(frameTransmit, 1'h0);
      ctl(8'h01);
      chkBit(startFrame, 1'h1);
      waitLow(0);
      rdCtl(8'h00);
      slow = 1'h1;
      ctl(8'h01);
      pulse(4);
      step();
      chkBit(startFrame, 1'h0);
      slow = 1'h0;
      endTest("master");
      wr(`LNMC_MODE_ADDR, 8'h80);
      ctl(8'h10);
      chkBit(dataAck, 1'h1);
      waitLow(1);
      rdCtl(8'h00);
      ctl(8'h80);
      step();
      chkBit(trafficIgnored, 1'h1);
      rdCtl(8'h00);
      pulse(3);
      step();
      chkBit(trafficIgnored, 1'h0);
      ctl(8'h40);
      pulse(2);
      step();
      chkBit(asleep, 1'h1);
      ctl(8'h42);
      chkBit(wakeSend, 1'h1);
      waitLow(2);
      waitLow(3);
      rdCtl(8'h40);
      ctl(8'h40);
      pulse(1);
      step();
      chkBit(asleep, 1'h1);
      ctl(8'h00);
      pulse(0);
      step();
      chkBit(asleep, 1'h0);
      endTest("slave");
      for (int k = 0; k < 4; k++)
      begin
         wr(`LNMC_IDX_ADDR, `LNMC_ID_IDX);
         wr(`LNMC_DATA_ADDR, {2'h3, k[1:0], 4'h5});
         rd(`LNMC_DATA_ADDR, {2'h0, k[1:0], 4'h5});
         chk8({2'h0, frameId}, {2'h0, k[1:0], 4'h5});
         chk8({4'h0, payloadBytes}, k < 2 ? 8'h02 : (k == 2 ? 8'h04 : 8'h08));
      end
      payloadSize = 4'h3;
      #1 chk8({4'h0, payloadBytes}, 8'h03);
      wr(`LNMC_MODE_ADDR, 8'h00);
      step();
      chkBit(ifaceActive, 1'h0);
      endTest("identifier");
      repeat (2) @(posedge sys_clk);
      finishTest();
   end
endmodule
